// [dv/siec_sink.sv]
// Entity byte sink standing for the receiver logic, with a stalling ready
`timescale 1ns/1ps
`default_nettype none
module siec_sink (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Entity byte stream
    input  wire logic [7:0] ent_data,
    input  wire logic       ent_valid,
    input  wire logic       ent_last,
    output logic            ent_ready
);
    logic [7:0] got[$];
    int         last_at;
    int         pos;
    int         need;
    int         bad_len;
    logic [1:0] cnt;

    // Ready drops one cycle in four so the source must hold its byte
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt       <= 2'h0;
            ent_ready <= 1'b0;
            pos        = 0;
            bad_len    = 0;
            last_at    = -1;
        end else begin
            cnt       <= cnt + 2'h1;
            ent_ready <= (cnt != 2'h1);
            if (ent_valid && ent_ready) begin
                if (pos == 0) begin
                    need = int'(ent_data[7:1]) + 2;
                end
                if (ent_last) begin
                    last_at = got.size();
                    if (pos != need - 1) begin
                        bad_len++;
                    end
                    pos = 0;
                end else begin
                    pos++;
                end
                got.push_back(ent_data);
            end
        end
    end
endmodule
`default_nettype wire

// [dv/tb_service_info_entity_codec.sv]
// Register-driven bench for the entity generator against the byte sink
`timescale 1ns/1ps
`default_nettype none
module tb_service_info_entity_codec;
    import siec_pkg::*;
    logic        clk;
    logic        resetn;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [7:0]  ent_data;
    logic        ent_valid;
    logic        ent_last;
    logic        ent_ready;
    logic [7:0]  exp[$];
    logic [31:0] rv;
    int          bad_count;
    int          num_checks;
    int          base;
    logic [3:0]  bad_flags [3];

    siec_gen i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ent_data(ent_data),
        .ent_valid(ent_valid), .ent_last(ent_last), .ent_ready(ent_ready));
    siec_sink i_sink (.clk(clk), .resetn(resetn), .ent_data(ent_data),
        .ent_valid(ent_valid), .ent_last(ent_last), .ent_ready(ent_ready));

    always #10 clk = ~clk;

    task automatic final_report();
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string m);
        num_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, want);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask

    task automatic run(input logic [31:0] c);
        int n;
        base = i_sink.got.size();
        wr(SIEC_OFF_CTRL, c);
        n = 0;
        while ((i_sink.got.size() < base + exp.size() || ent_valid !== 1'b0) && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n == 300) begin
            chk(32'h0, 32'h1, "stream timeout");
            final_report();
        end
        for (int i = 0; i < exp.size(); i++) begin
            chk(i_sink.got[base + i], exp[i], "entity byte");
        end
        chk(i_sink.last_at, base + exp.size() - 1, "last byte mark");
        chk(i_sink.got.size(), base + exp.size(), "byte count");
    endtask

    initial begin
        clk       = 1'b0;
        resetn    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(SIEC_OFF_CTRL);
        chk(rv, 32'h0000_0001, "ctrl reset");
        rd(SIEC_OFF_LABEL);
        chk(rv, 32'h0000_0100, "label reset");
        rd(SIEC_OFF_ALTF);
        chk(rv, 32'h0001_0000, "list reset");
        rd(SIEC_OFF_BYTE);
        chk(rv, 32'h0000_0000, "write-only read");
        rd(8'h1C);
        chk(rv, 32'h0000_0000, "unmapped read");
        // Label whose last byte is zero: length, not terminator, ends it
        wr(SIEC_OFF_LABEL, 32'h0000_0302);
        wr(SIEC_OFF_BYTE, 32'h0000_00C3);
        wr(SIEC_OFF_BYTE, 32'h0000_0141);
        wr(SIEC_OFF_BYTE, 32'h0000_0200);
        exp = '{8'h06, 8'h18, 8'hC3, 8'h41, 8'h00};
        run(32'h0000_0005);
        // Shared parameters, next configuration
        wr(SIEC_OFF_ACCESS, 32'h0002_A52D);
        wr(SIEC_OFF_BYTE, 32'h0000_005A);
        wr(SIEC_OFF_BYTE, 32'h0000_013C);
        exp = '{8'h07, 8'h27, 8'hA5, 8'h5A, 8'h3C};
        run(32'h0000_0006);
        // Data service forces the audio flag low
        wr(SIEC_OFF_ACCESS, 32'h0000_111F);
        exp = '{8'h02, 8'h2D, 8'h11};
        run(32'h0000_0006);
        wr(SIEC_OFF_ALTF, 32'h0002_03AF);
        wr(SIEC_OFF_FREQ, 32'h0000_7FFF);
        wr(SIEC_OFF_FREQ, 32'h0001_0123);
        exp = '{8'h0D, 8'h3F, 8'hA0, 8'h30, 8'h7F, 8'hFF, 8'h01, 8'h23};
        run(32'h0000_0007);
        rd(SIEC_OFF_STATUS);
        chk(rv, 32'h0000_0004, "status after list");
        run(32'h0000_0007);
        wr(SIEC_OFF_ALTF, 32'h0001_0001);
        exp = '{8'h04, 8'h38, 8'h7F, 8'hFF};
        run(32'h0000_0007);
        // Unused flag combinations are refused
        bad_flags = '{4'h2, 4'h6, 4'h5};
        foreach (bad_flags[k]) begin
            base = i_sink.got.size();
            wr(SIEC_OFF_ALTF, {28'h0001_000, bad_flags[k]});
            wr(SIEC_OFF_CTRL, 32'h0000_0007);
            repeat (4) @(posedge clk);
            chk(i_sink.got.size(), base, "refused stream");
            rd(SIEC_OFF_STATUS);
            chk(rv & 32'h0000_0003, 32'h0000_0002, "error flag");
            wr(SIEC_OFF_CTRL, 32'h0000_000B);
            rd(SIEC_OFF_STATUS);
            chk(rv & 32'h0000_0003, 32'h0000_0000, "error clear");
        end
        chk(i_sink.bad_len, 0, "length consistency");
        final_report();
    end
endmodule
`default_nettype wire

// [include/siec_pkg.sv]
// Constants for the service information entity generator
package siec_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] SIEC_OFF_CTRL   = 8'h00;
    localparam logic [7:0] SIEC_OFF_LABEL  = 8'h04;
    localparam logic [7:0] SIEC_OFF_ACCESS = 8'h08;
    localparam logic [7:0] SIEC_OFF_ALTF   = 8'h0C;
    localparam logic [7:0] SIEC_OFF_BYTE   = 8'h10;
    localparam logic [7:0] SIEC_OFF_FREQ   = 8'h14;
    localparam logic [7:0] SIEC_OFF_STATUS = 8'h18;
    // Entity type codes
    localparam logic [3:0] SIEC_TYPE_LABEL  = 4'h1;
    localparam logic [3:0] SIEC_TYPE_ACCESS = 4'h2;
    localparam logic [3:0] SIEC_TYPE_ALTF   = 4'h3;
    // Field positions
    localparam int SIEC_CTRL_START   = 2;
    localparam int SIEC_CTRL_ERRCLR  = 3;
    localparam int SIEC_LABEL_LEN    = 8;
    localparam int SIEC_CA_AUDIO     = 2;
    localparam int SIEC_CA_DATA      = 3;
    localparam int SIEC_CA_DSVC      = 4;
    localparam int SIEC_CA_NEXT      = 5;
    localparam int SIEC_CA_SYS       = 8;
    localparam int SIEC_CA_XLEN      = 16;
    localparam int SIEC_AF_SVC       = 4;
    localparam int SIEC_AF_REGION    = 8;
    localparam int SIEC_AF_SCHED     = 12;
    localparam int SIEC_AF_CNT       = 16;
    localparam int SIEC_BYTE_IDX     = 8;
    localparam int SIEC_FREQ_IDX     = 16;
    // Reset values
    localparam logic [31:0] SIEC_RST_WORD = 32'h0000_0000;
    localparam logic [6:0]  SIEC_RST_LEN  = 7'h01;
    localparam logic [4:0]  SIEC_RST_CNT  = 5'h01;
    // Generator states
    typedef enum logic [1:0] {
        SIEC_IDLE = 2'b01,
        SIEC_SEND = 2'b10
    } siec_state_t;
endpackage

// [logic/siec_gen.sv]
// Service information entity generator: label, access and frequency list
// Behaviour
// - Type code 1 label, 2 access parameters, 3 frequency list.
// - Label body: 2-bit service index, two zero bits, label bytes.
// - Label holds 1 to 64 bytes, up to 16 characters.
// - Label uses unique version flag; sent on each start command.
// - Access body: index, audio flag, data flag, system id, extra bytes.
// - Audio access flag 1 for audio stream, forced 0 for data service.
// - Data access flag 1 when a data stream is covered.
// - Shared parameters send one entity with both flags set.
// - Access entity uses reconfiguration flag, list entity uses list flag.
// - First list flag marks a synchronous multiplex.
// - Second list flag: 0 base layer, 1 enhancement layer.
// - Third list flag: 1 when only some services are available.
// - Only flag combinations 000, 001, 100, 110, 111 are emitted.
// - Fourth flag set when region or schedule limits the list.
// - Subset byte present when restricted: four service bits, four zeros.
// - Region and schedule byte present only when fourth flag set.
// - Index 0 means unspecified, 1 to 15 a defined one.
// - One to sixteen entries, zero bit then 15-bit value.
// - Frequency value is an unsigned count of kilohertz.
// - All reserved bits are driven to zero.
// - Header: 7-bit body length, version flag, 4-bit type.
// - Length counts body bytes after the first four body bits.
// - Unique flag is 0; reconfiguration flag 0 current, 1 next.
// - List flag toggles whenever list data changed since last send.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module siec_gen #(
    parameter int LABEL_MAX = 64,
    parameter int FREQ_MAX  = 16
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Entity byte stream
    output logic      [7:0]  ent_data,
    output logic             ent_valid,
    output logic             ent_last,
    input  wire logic        ent_ready
);
    import siec_pkg::*;

    typedef struct packed {
        siec_state_t                  st;
        logic [1:0]                   kind;
        logic [6:0]                   pos;
        logic [7:0]                   obyte;
        logic                         err;
        logic                         af_ver;
        logic                         af_dirty;
        logic [1:0]                   lbl_short;
        logic [6:0]                   lbl_len;
        logic [1:0]                   ca_short;
        logic                         ca_audio;
        logic                         ca_data;
        logic                         ca_dsvc;
        logic                         ca_next;
        logic [7:0]                   ca_sys;
        logic [6:0]                   ca_xlen;
        logic [3:0]                   af_flags;
        logic [3:0]                   af_svc;
        logic [3:0]                   af_region;
        logic [3:0]                   af_sched;
        logic [4:0]                   af_cnt;
        logic [LABEL_MAX-1:0][7:0]    mem;
        logic [FREQ_MAX-1:0][14:0]    freq;
        logic [31:0]                  rdata;
    } siec_regs_t;

    siec_regs_t s_q;
    siec_regs_t s_d;

    // Body length in bytes beyond the first nibble
    function automatic logic [6:0] ent_len(input siec_regs_t s);
        logic [6:0] n;
        n = 7'h00;
        unique case (s.kind)
            2'd1: n = s.lbl_len;
            2'd2: n = 7'(s.ca_xlen + 7'd1);
            default: n = 7'(7'(s.af_flags[2]) + 7'(s.af_flags[3]) + 7'({s.af_cnt, 1'b0}));
        endcase
        return n;
    endfunction

    // Sync, layer and restriction flags as the entity orders them
    function automatic logic combo_ok(input logic [3:0] f);
        logic [2:0] c;
        c = {f[0], f[1], f[2]};
        return !(c inside {3'b010, 3'b011, 3'b101});
    endfunction

    // Flag nibble on the wire: sync first, region/schedule last
    function automatic logic [3:0] flag_nib(input logic [3:0] f);
        return {f[0], f[1], f[2], f[3]};
    endfunction

    // Entity byte at stream position p
    function automatic logic [7:0] byte_at(input siec_regs_t s, input logic [6:0] p);
        logic [7:0] b;
        logic [6:0] k;
        logic [6:0] off;
        logic [3:0] ent;
        b   = 8'h00;
        k   = 7'(p - 7'd2);
        off = 7'(k - 7'(s.af_flags[2]) - 7'(s.af_flags[3]));
        ent = off[4:1];
        if (p == 7'd0) begin
            unique case (s.kind)
                2'd1: b = {ent_len(s), 1'b0};
                2'd2: b = {ent_len(s), s.ca_next};
                default: b = {ent_len(s), s.af_ver};
            endcase
        end else if (p == 7'd1) begin
            unique case (s.kind)
                2'd1: b = {SIEC_TYPE_LABEL, s.lbl_short, 2'b00};
                2'd2: b = {SIEC_TYPE_ACCESS, s.ca_short,
                           s.ca_audio & ~s.ca_dsvc, s.ca_data};
                default: b = {SIEC_TYPE_ALTF, flag_nib(s.af_flags)};
            endcase
        end else begin
            unique case (s.kind)
                2'd1: b = s.mem[k[5:0]];
                2'd2: b = (k == 7'd0) ? s.ca_sys : s.mem[6'(k - 7'd1)];
                default: begin
                    if (s.af_flags[2] && k == 7'd0) begin
                        b = {s.af_svc, 4'h0};
                    end else if (s.af_flags[3] && k == 7'(s.af_flags[2])) begin
                        b = {s.af_region, s.af_sched};
                    end else if (!off[0]) begin
                        b = {1'b0, s.freq[ent][14:8]};
                    end else begin
                        b = s.freq[ent][7:0];
                    end
                end
            endcase
        end
        return b;
    endfunction

    // Start command checks
    function automatic logic start_ok(input siec_regs_t s);
        logic ok;
        ok = 1'b0;
        unique case (s.kind)
            2'd1: ok = s.lbl_len != 7'd0 && 32'(s.lbl_len) <= LABEL_MAX;
            2'd2: ok = 32'(s.ca_xlen) < LABEL_MAX;
            2'd3: ok = s.af_cnt != 5'd0 && 32'(s.af_cnt) <= FREQ_MAX
                       && combo_ok(s.af_flags);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    logic fire;
    logic is_last;
    assign fire    = ent_valid && ent_ready;
    assign is_last = s_q.pos == 7'(ent_len(s_q) + 7'd1);

    always_comb begin
        siec_regs_t t;
        s_d     = s_q;
        t       = s_q;
        s_d.rdata = SIEC_RST_WORD;
        if (reg_rd) begin
            unique case (reg_addr)
                SIEC_OFF_CTRL:   s_d.rdata = {30'h0000_0000, s_q.kind};
                SIEC_OFF_LABEL:  s_d.rdata = {17'h0_0000, s_q.lbl_len, 6'h00, s_q.lbl_short};
                SIEC_OFF_ACCESS: s_d.rdata = {9'h000, s_q.ca_xlen, s_q.ca_sys, 2'b00,
                                              s_q.ca_next, s_q.ca_dsvc, s_q.ca_data,
                                              s_q.ca_audio, s_q.ca_short};
                SIEC_OFF_ALTF:   s_d.rdata = {11'h000, s_q.af_cnt, s_q.af_sched,
                                              s_q.af_region, s_q.af_svc, s_q.af_flags};
                SIEC_OFF_STATUS: s_d.rdata = {28'h000_0000, s_q.af_dirty, s_q.af_ver,
                                              s_q.err, s_q.st == SIEC_SEND};
                default:         s_d.rdata = SIEC_RST_WORD;
            endcase
        end
        // Config is frozen while sending, so a stream never mixes two setups
        if (reg_wr && s_q.st == SIEC_IDLE) begin
            unique case (reg_addr)
                SIEC_OFF_CTRL: begin
                    s_d.kind = reg_wdata[1:0];
                    if (reg_wdata[SIEC_CTRL_ERRCLR]) begin
                        s_d.err = 1'b0;
                    end
                end
                SIEC_OFF_LABEL: begin
                    s_d.lbl_short = reg_wdata[1:0];
                    s_d.lbl_len   = reg_wdata[SIEC_LABEL_LEN +: 7];
                end
                SIEC_OFF_ACCESS: begin
                    s_d.ca_short = reg_wdata[1:0];
                    s_d.ca_audio = reg_wdata[SIEC_CA_AUDIO];
                    s_d.ca_data  = reg_wdata[SIEC_CA_DATA];
                    s_d.ca_dsvc  = reg_wdata[SIEC_CA_DSVC];
                    s_d.ca_next  = reg_wdata[SIEC_CA_NEXT];
                    s_d.ca_sys   = reg_wdata[SIEC_CA_SYS +: 8];
                    s_d.ca_xlen  = reg_wdata[SIEC_CA_XLEN +: 7];
                end
                SIEC_OFF_ALTF: begin
                    s_d.af_flags  = reg_wdata[3:0];
                    s_d.af_svc    = reg_wdata[SIEC_AF_SVC +: 4];
                    s_d.af_region = reg_wdata[SIEC_AF_REGION +: 4];
                    s_d.af_sched  = reg_wdata[SIEC_AF_SCHED +: 4];
                    s_d.af_cnt    = reg_wdata[SIEC_AF_CNT +: 5];
                    s_d.af_dirty  = 1'b1;
                end
                SIEC_OFF_BYTE: begin
                    s_d.mem[reg_wdata[SIEC_BYTE_IDX +: $clog2(LABEL_MAX)]] = reg_wdata[7:0];
                end
                SIEC_OFF_FREQ: begin
                    s_d.freq[reg_wdata[SIEC_FREQ_IDX +: $clog2(FREQ_MAX)]] = reg_wdata[14:0];
                    s_d.af_dirty = 1'b1;
                end
                default: ;
            endcase
            if (reg_addr == SIEC_OFF_CTRL && reg_wdata[SIEC_CTRL_START]) begin
                if (start_ok(s_d)) begin
                    if (s_d.kind == 2'd3 && s_d.af_dirty) begin
                        s_d.af_ver   = ~s_d.af_ver;
                        s_d.af_dirty = 1'b0;
                    end
                    s_d.st    = SIEC_SEND;
                    s_d.pos   = 7'd0;
                    s_d.obyte = byte_at(s_d, 7'd0);
                end else begin
                    s_d.err = 1'b1;
                end
            end
        end
        if (fire) begin
            if (is_last) begin
                s_d.st = SIEC_IDLE;
            end else begin
                t         = s_d;
                s_d.pos   = 7'(s_q.pos + 7'd1);
                s_d.obyte = byte_at(t, 7'(s_q.pos + 7'd1));
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q         <= '0;
            s_q.st      <= SIEC_IDLE;
            s_q.kind    <= 2'd1;
            s_q.lbl_len <= SIEC_RST_LEN;
            s_q.af_cnt  <= SIEC_RST_CNT;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign ent_data  = s_q.obyte;
    assign ent_valid = s_q.st == SIEC_SEND;
    assign ent_last  = ent_valid && is_last;

    // Check helpers, worked out from the fields rather than through ent_len
    logic [6:0] chk_opt;
    logic [6:0] chk_len;
    logic [6:0] chk_off;
    logic       chk_fhi;
    assign chk_opt = 7'(7'(s_q.af_flags[2]) + 7'(s_q.af_flags[3]));
    assign chk_off = 7'(s_q.pos - 7'd2 - chk_opt);
    assign chk_fhi = s_q.kind == 2'd3 && s_q.pos >= 7'(chk_opt + 7'd2) && !chk_off[0];
    always_comb begin
        unique case (s_q.kind)
            2'd1: chk_len = s_q.lbl_len;
            2'd2: chk_len = 7'(s_q.ca_xlen + 7'd1);
            default: chk_len = 7'(chk_opt + 7'({s_q.af_cnt, 1'b0}));
        endcase
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_type_code: assert property (ent_valid && s_q.pos == 7'd1 |->
        ent_data[7:4] == {2'b00, s_q.kind}) else $error("bad type code");
    a_label_rsv: assert property (ent_valid && s_q.pos == 7'd1 && s_q.kind == 2'd1 |->
        ent_data[1:0] == 2'b00) else $error("label reserved bits set");
    a_label_ver: assert property (ent_valid && s_q.pos == 7'd0 && s_q.kind == 2'd1 |->
        !ent_data[0] && ent_data[7:1] <= 7'd64) else $error("label header bad");
    a_audio_data: assert property (ent_valid && s_q.pos == 7'd1 && s_q.kind == 2'd2 &&
        s_q.ca_dsvc |-> !ent_data[1]) else $error("audio flag on data service");
    a_combo_legal: assert property (ent_valid && s_q.pos == 7'd1 && s_q.kind == 2'd3 |->
        !(ent_data[3:1] inside {3'b010, 3'b011, 3'b101})) else $error("bad flags");
    a_freq_rsv: assert property (ent_valid && chk_fhi |-> !ent_data[7])
        else $error("frequency reserved bit set");
    a_last_len: assert property (ent_last |-> s_q.pos == 7'(chk_len + 7'd1))
        else $error("length mismatch");
    a_count_range: assert property (ent_valid && s_q.kind == 2'd3 |->
        s_q.af_cnt >= 5'd1 && s_q.af_cnt <= 5'd16) else $error("entry count");
    a_ver_toggle: assert property (s_q.st == SIEC_IDLE && s_d.st == SIEC_SEND &&
        s_d.kind == 2'd3 && s_q.af_dirty |=> s_q.af_ver != $past(s_q.af_ver))
        else $error("list version kept");
    a_hold_stall: assert property (ent_valid && !ent_ready |=> ent_valid &&
        $stable(ent_data)) else $error("byte dropped under stall");
    // Header and body fields
    a_hdr_len: assert property (ent_valid && s_q.pos == 7'd0 |->
        ent_data[7:1] == chk_len) else $error("header length wrong");
    a_access_ver: assert property (ent_valid && s_q.pos == 7'd0 && s_q.kind == 2'd2 |->
        ent_data[0] == s_q.ca_next) else $error("access version flag wrong");
    a_data_flag: assert property (ent_valid && s_q.pos == 7'd1 && s_q.kind == 2'd2 |->
        ent_data[0] == s_q.ca_data) else $error("data access flag wrong");
    a_access_sys: assert property (ent_valid && s_q.pos == 7'd2 && s_q.kind == 2'd2 |->
        ent_data == s_q.ca_sys) else $error("access system byte wrong");
    a_subset_rsv: assert property (ent_valid && s_q.kind == 2'd3 && s_q.af_flags[2] &&
        s_q.pos == 7'd2 |-> ent_data[3:0] == 4'h0) else $error("subset reserved bits set");
    a_region_byte: assert property (ent_valid && s_q.kind == 2'd3 && s_q.af_flags[3] &&
        s_q.pos == 7'(7'd2 + 7'(s_q.af_flags[2])) |->
        ent_data == {s_q.af_region, s_q.af_sched}) else $error("region byte wrong");
    // Register port and stream framing
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read slot");
    a_kind_frozen: assert property (ent_valid |=> s_q.kind == $past(s_q.kind))
        else $error("setup changed mid entity");
    a_first_byte: assert property (!ent_valid && s_d.st == SIEC_SEND |=>
        ent_valid && s_q.pos == 7'd0) else $error("start did not open entity");
    a_advance: assert property (ent_valid && ent_ready && !ent_last |=>
        ent_valid && s_q.pos == 7'($past(s_q.pos) + 7'd1)) else $error("byte skipped");
    a_end_idle: assert property (ent_valid && ent_ready && ent_last |=>
        !ent_valid) else $error("stream ran past last byte");
    a_refuse_combo: assert property (reg_wr && reg_addr == SIEC_OFF_CTRL && !ent_valid &&
        reg_wdata[SIEC_CTRL_START] && reg_wdata[1:0] == 2'd3 && !combo_ok(s_q.af_flags)
        |=> !ent_valid && s_q.err) else $error("unused flag combination accepted");

    c_label: cover property (ent_last && s_q.kind == 2'd1);
    c_access: cover property (ent_last && s_q.kind == 2'd2 && s_q.ca_audio && s_q.ca_data);
    c_altf_full: cover property (ent_last && s_q.kind == 2'd3 && s_q.af_flags[3:2] == 2'b11);
    c_refused: cover property (!s_q.err ##1 s_q.err);
    c_stall: cover property (ent_valid && !ent_ready ##1 ent_valid && ent_ready);
endmodule
`default_nettype wire
